/* File: core/adc_ctl_pkg.sv */
// constants, field layout and types for the converter mode and coding block
// assumes a 125 MHz register clock and a 14-bit SAR core beside it
package adc_ctl_pkg;

  localparam int RESULT_W = 14;
  localparam int ADDR_W   = 4;
  localparam int CNT_W    = 8;
  localparam int CLK_MHZ  = 125;

  // conversion phase lengths per mode, in ns and in clock cycles
  localparam int CONV_FAST_NS  = 700;
  localparam int CONV_STD_NS   = 950;
  localparam int CONV_LOW_NS   = 1150;
  localparam int CONV_FAST_CYC = (CONV_FAST_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_STD_CYC  = (CONV_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_LOW_CYC  = (CONV_LOW_NS * CLK_MHZ + 999) / 1000;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CFG_OFFSET    = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;
  localparam logic [ADDR_W-1:0] RESULT_OFFSET = 4'h8;

  // configuration fields
  localparam int CFG_W        = 6;
  localparam int CFG_SW_BIT   = 0;
  localparam int CFG_MODE_LSB = 1;
  localparam int CFG_FMT_BIT  = 3;
  localparam int CFG_BIP_BIT  = 4;
  localparam int CFG_WIDE_BIT = 5;
  localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;

  // status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_PWR_BIT  = 1;
  localparam int ST_MODE_LSB = 2;
  localparam int ST_FMT_BIT  = 4;
  localparam int ST_BIP_BIT  = 5;
  localparam int ST_WIDE_BIT = 6;
  localparam int ST_SW_BIT   = 7;

  // software mode field codes
  localparam logic [1:0] MODE_CODE_STD  = 2'h0;
  localparam logic [1:0] MODE_CODE_FAST = 2'h1;
  localparam logic [1:0] MODE_CODE_LOW  = 2'h2;

  localparam logic [RESULT_W-1:0] RESULT_RESET = 14'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_STANDARD,
    MODE_FAST,
    MODE_LOW_POWER
  } mode_e;

  typedef enum logic {
    ST_ACQUIRE,
    ST_CONVERT
  } conv_state_e;

endpackage : adc_ctl_pkg

/* File: core/code_formatter.sv */
// clamps a raw SAR code and maps it to straight binary or twos complement
// assumes the raw code is straight binary with separate overrange flags
`timescale 1ns/1ps
module code_formatter
  import adc_ctl_pkg::*;
#(
  parameter int W = RESULT_W
) (
  input  wire logic [W-1:0] sar_code,
  input  wire logic         over,
  input  wire logic         under,
  input  wire logic         binary,
  output logic      [W-1:0] code
);

  wire [W-1:0] msb_mask = {1'b1, {(W-1){1'b0}}};
  wire [W-1:0] clamped;

  // overrange clamps to top or bottom code
  assign clamped = over ? {W{1'b1}} : (under ? {W{1'b0}} : sar_code);
  // twos complement by msb inversion
  assign code = binary ? clamped : (clamped ^ msb_mask);

endmodule : code_formatter

/* File: core/adc_mode_and_output_coding.sv */
// converter mode, range and output coding control with AXI4-Lite registers
// assumes pins synchronous to aclk and a SAR core giving raw code and flags
`timescale 1ns/1ps
module adc_mode_and_output_coding
  import adc_ctl_pkg::*;
#(
  parameter int CONV_FAST = CONV_FAST_CYC,
  parameter int CONV_STD  = CONV_STD_CYC,
  parameter int CONV_LOW  = CONV_LOW_CYC
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                clk_en,
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  input  wire logic                fast_mode_select,
  input  wire logic                low_power_select,
  input  wire logic                code_format_select,
  input  wire logic                bipolar_range_select,
  input  wire logic                wide_range_select,
  input  wire logic                convert_start_n,
  input  wire logic [RESULT_W-1:0] sar_code,
  input  wire logic                sar_over,
  input  wire logic                sar_under,
  output logic                     busy,
  output logic [RESULT_W-1:0]      result,
  output logic                     conv_power_on,
  output logic                     range_bipolar,
  output logic                     range_wide
);

  logic [CFG_W-1:0]    cfg;
  logic                aw_held;
  logic                w_held;
  logic [ADDR_W-1:0]   waddr;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  logic                start_n_prev;
  conv_state_e         state;
  logic [CNT_W-1:0]    cnt;
  mode_e               act_mode;
  logic                act_binary;

  // mode selection from pins and from software
  wire   sw_ctl = cfg[CFG_SW_BIT];
  wire   [1:0] sw_mode_code = cfg[CFG_MODE_LSB +: 2];
  mode_e pin_mode;
  mode_e sw_mode;
  mode_e sel_mode;

  assign pin_mode = (fast_mode_select && !low_power_select) ? MODE_FAST :
                    (!fast_mode_select && low_power_select) ? MODE_LOW_POWER :
                    MODE_STANDARD;
  assign sw_mode  = (sw_mode_code == MODE_CODE_FAST) ? MODE_FAST :
                    (sw_mode_code == MODE_CODE_LOW)  ? MODE_LOW_POWER :
                    MODE_STANDARD;
  assign sel_mode = sw_ctl ? sw_mode : pin_mode;

  // software control ignores coding and range pins
  wire sel_binary = sw_ctl ? cfg[CFG_FMT_BIT] : code_format_select;
  // high levels bipolar and wide
  wire sel_bip    = sw_ctl ? cfg[CFG_BIP_BIT] : bipolar_range_select;
  wire sel_wide   = sw_ctl ? cfg[CFG_WIDE_BIT] : wide_range_select;

  // conversion length of the selected mode
  wire [CNT_W-1:0] conv_last =
    (sel_mode == MODE_FAST)      ? CNT_W'(CONV_FAST - 1) :
    (sel_mode == MODE_LOW_POWER) ? CNT_W'(CONV_LOW - 1) :
    CNT_W'(CONV_STD - 1);

  wire start_fall = start_n_prev && !convert_start_n;
  wire conv_go    = (state == ST_ACQUIRE) && start_fall;
  wire conv_done  = (state == ST_CONVERT) && (cnt == {CNT_W{1'b0}});

  logic [RESULT_W-1:0] formatted;

  code_formatter #(
    .W        (RESULT_W)
  ) u_fmt (
    .sar_code (sar_code),
    .over     (sar_over),
    .under    (sar_under),
    .binary   (act_binary),
    .code     (formatted)
  );

  // conversion sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_n_prev  <= 1'b1;
      state         <= ST_ACQUIRE;
      cnt           <= {CNT_W{1'b0}};
      busy          <= 1'b0;
      result        <= RESULT_RESET;
      conv_power_on <= 1'b0;
      act_mode      <= MODE_STANDARD;
      act_binary    <= 1'b0;
      range_bipolar <= 1'b0;
      range_wide    <= 1'b0;
    end else if (clk_en) begin
      start_n_prev <= convert_start_n;
      case (state)
        ST_ACQUIRE: begin
          // settings track during acquisition
          range_bipolar <= sel_bip;
          range_wide    <= sel_wide;
          if (sel_mode != MODE_LOW_POWER) begin
            conv_power_on <= 1'b1;
          end
          if (conv_go) begin
            // latched at conversion start
            state         <= ST_CONVERT;
            busy          <= 1'b1;
            cnt           <= conv_last;
            act_mode      <= sel_mode;
            act_binary    <= sel_binary;
            conv_power_on <= 1'b1;
          end
        end
        ST_CONVERT: begin
          if (conv_done) begin
            // code registered on the edge busy falls
            result <= formatted;
            busy   <= 1'b0;
            state  <= ST_ACQUIRE;
            // power down until next start or until low power is deselected
            if (act_mode == MODE_LOW_POWER) begin
              conv_power_on <= 1'b0;
            end
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        default: begin
          state <= ST_ACQUIRE;
        end
      endcase
    end
  end

  // register decode
  wire do_write   = aw_held && w_held && !bvalid;
  wire wr_cfg     = waddr == CFG_OFFSET;
  wire wr_ro      = (waddr == STATUS_OFFSET) || (waddr == RESULT_OFFSET);
  wire rd_cfg     = araddr == CFG_OFFSET;
  wire rd_status  = araddr == STATUS_OFFSET;
  wire rd_result  = araddr == RESULT_OFFSET;
  wire rd_hit     = rd_cfg || rd_status || rd_result;

  wire [31:0] status_word = {
    24'h000000,
    sw_ctl,
    range_wide,
    range_bipolar,
    act_binary,
    act_mode,
    conv_power_on,
    busy
  };

  wire [31:0] rd_word =
    rd_cfg    ? {{(32-CFG_W){1'b0}}, cfg} :
    rd_status ? status_word :
    rd_result ? {{(32-RESULT_W){1'b0}}, result} :
    32'h00000000;

  // configuration register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= CFG_RESET;
    end else if (clk_en && do_write && wr_cfg && wstrb_q[0]) begin
      cfg <= wdata_q[CFG_W-1:0];
    end
  end

  // write channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      waddr   <= {ADDR_W{1'b0}};
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else if (clk_en) begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        waddr   <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held  <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        wready  <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        if (wr_cfg) begin
          bresp <= RESP_OKAY;
        end else if (wr_ro) begin
          bresp <= RESP_OKAY;
        end else begin
          bresp <= RESP_SLVERR;
        end
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // read channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= RESP_OKAY;
    end else if (clk_en) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_word;
        rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule : adc_mode_and_output_coding

/* File: sim/adc_coding_chk.sv */
// assertions on the mode and coding block ports
// assumes it is bound into each instance of the top module
`timescale 1ns/1ps
module adc_coding_chk
  import adc_ctl_pkg::*;
(
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                clk_en,
  input wire logic                convert_start_n,
  input wire logic                busy,
  input wire logic                conv_power_on,
  input wire logic [RESULT_W-1:0] result,
  input wire logic                sar_over,
  input wire logic                sar_under,
  input wire logic                range_bipolar,
  input wire logic                range_wide,
  input wire logic                awvalid,
  input wire logic                awready,
  input wire logic                wvalid,
  input wire logic                wready,
  input wire logic                bvalid,
  input wire logic                arvalid,
  input wire logic                arready,
  input wire logic                rvalid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_start;
    clk_en && $fell(convert_start_n) && !busy;
  endsequence
  sequence s_conv;
    busy [*4];
  endsequence
  a_start_conv: assert property (s_start |=> s_conv)
    else $error("conversion did not start");
  a_power_wake: assert property (s_start |=> conv_power_on)
    else $error("power not on at start");
  a_busy_power: assert property (busy |-> conv_power_on)
    else $error("converting while powered down");
  a_result_end: assert property ($changed(result) |-> $fell(busy))
    else $error("result moved outside conversion end");
  a_clamp_high: assert property ($fell(busy) && $past(sar_over)
    |-> result inside {14'h3FFF, 14'h1FFF})
    else $error("overrange not clamped high");
  a_clamp_low: assert property ($fell(busy) && $past(sar_under)
    && !$past(sar_over) |-> result inside {14'h0000, 14'h2000})
    else $error("underrange not clamped low");
  a_range_hold: assert property (busy && $past(busy)
    |-> $stable(range_bipolar) && $stable(range_wide))
    else $error("range moved during conversion");
  a_write_resp: assert property (awvalid && awready && wvalid && wready
    |=> !awready && !bvalid ##1 bvalid)
    else $error("write response late");
  a_read_resp: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read response late");
endmodule : adc_coding_chk

bind adc_mode_and_output_coding adc_coding_chk i_chk (.*);

/* File: sim/sar_core_model.sv */
// behavioural sar core: raw code and overrange flags from an input level
// assumes the level is held steady across each conversion
`timescale 1ns/1ps
module sar_core_model
  import adc_ctl_pkg::*;
(
  input  wire logic signed [15:0] vin,
  output logic [RESULT_W-1:0]     sar_code,
  output logic                    sar_over,
  output logic                    sar_under
);
  // raw low bits pass even when flagged; clamping is the block's job
  assign sar_over  = vin > 16'sh3FFF;
  assign sar_under = vin < 16'sh0000;
  assign sar_code  = vin[13:0];
endmodule : sar_core_model

/* File: sim/adc_mode_and_output_coding_tb_top.sv */
// bench for the mode and coding block with register and pin tests
// assumes the sar model and the checker bind are compiled alongside
`timescale 1ns/1ps
module adc_mode_and_output_coding_tb_top import adc_ctl_pkg::*;;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, cs_n = 1, ce = 1;
  logic fms = 0, lps = 0, cfs = 1, bps = 0, wrs = 0;
  logic [ADDR_W-1:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rd_q;
  logic [1:0] bresp, rresp, resp_q;
  logic awready, wready, bvalid, arready, rvalid, busy, cpo, rbi, rwi;
  logic [RESULT_W-1:0] sar_code, result;
  logic sar_over, sar_under;
  logic signed [15:0] vin = 16'sh0000;
  logic signed [15:0] vt [6] = '{16'sh0000, 16'sh2000, 16'sh3FFF,
                                 16'sh1FFF, 16'sh4E20, 16'shFFFB};
  logic [13:0] et [6] = '{14'h0000, 14'h2000, 14'h3FFF,
                          14'h1FFF, 14'h3FFF, 14'h0000};
  int num_errors = 0, tests_run = 0, n;
  localparam int START_GAP = 187; // cycles per start at 670 kSPS, 8 ns
  always #4 aclk = ~aclk;
  adc_mode_and_output_coding #(.CONV_FAST(4), .CONV_STD(5), .CONV_LOW(6))
  i_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .fast_mode_select(fms), .low_power_select(lps),
    .code_format_select(cfs), .bipolar_range_select(bps),
    .wide_range_select(wrs), .convert_start_n(cs_n),
    .sar_code(sar_code), .sar_over(sar_over), .sar_under(sar_under),
    .busy(busy), .result(result), .conv_power_on(cpo),
    .range_bipolar(rbi), .range_wide(rwi));
  sar_core_model i_sar (.vin(vin), .sar_code(sar_code),
    .sar_over(sar_over), .sar_under(sar_under));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp_q = bresp;
    bready <= 1'b0;
  endtask : wr
  task rd(input logic [ADDR_W-1:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_q = rdata;
    resp_q = rresp;
    rready <= 1'b0;
  endtask : rd
  task conv;
    repeat (START_GAP) @(posedge aclk); // start spacing
    @(posedge aclk);
    cs_n <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      #1;
      n++;
    end while (busy === 1'b1 && n < 99);
    @(posedge aclk);
    cs_n <= 1'b1;
  endtask : conv
  task test_done;
    if (num_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  initial begin
    #100000;
    num_errors++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      fms <= i[1];
      lps <= i[0];
      conv;
      check(n, (i == 1) ? 7 : (i == 2) ? 5 : 6);
      check(cpo, i != 1);
    end
    fms <= 1'b1;
    lps <= 1'b0;
    for (int f = 0; f < 2; f++)
      for (int k = 0; k < 6; k++) begin
        cfs <= f[0];
        vin <= vt[k];
        conv;
        check(result, f ? et[k] : et[k] ^ 14'h2000);
      end
    for (int r = 0; r < 4; r++) begin
      @(posedge aclk);
      bps <= r[1];
      wrs <= r[0];
      repeat (2) @(posedge aclk);
      #1;
      check({rbi, rwi}, r[1:0]);
    end
    @(posedge aclk);
    bps <= 1'b0;
    wrs <= 1'b0;
    cfs <= 1'b0;
    wr(CFG_OFFSET, 32'h0000_003D);
    check(resp_q, RESP_OKAY);
    vin <= 16'sh0001;
    conv;
    check(n, 7);
    check(result, 14'h0001);
    check({rbi, rwi}, 2'h3);
    rd(STATUS_OFFSET);
    check(rd_q, 32'h0000_00F8);
    wr(RESULT_OFFSET, 32'h0000_1234);
    check(resp_q, RESP_OKAY);
    rd(RESULT_OFFSET);
    check(rd_q, 32'h0000_0001);
    rd(4'hC);
    check(resp_q, RESP_SLVERR);
    check(rd_q, 32'h0000_0000);
    rd(CFG_OFFSET);
    check(rd_q, 32'h0000_003D);
    wr(CFG_OFFSET, 32'h0000_0007);
    conv;
    check(n, 6);
    check(result, 14'h2001);
    @(posedge aclk);
    ce <= 1'b0;
    cs_n <= 1'b0;
    repeat (3) @(posedge aclk);
    #1;
    check(busy, 1'b0);
    @(posedge aclk);
    ce <= 1'b1;
    repeat (2) @(posedge aclk);
    #1;
    check(busy, 1'b1);
    repeat (8) @(posedge aclk);
    cs_n <= 1'b1;
    #1;
    check(busy, 1'b0);
    test_done;
  end
endmodule : adc_mode_and_output_coding_tb_top
